// ===== src/bis_consts.svh
/*
  constants of the block interrupt summary: register offsets, bit positions,
  reset values and source vector layout.
  assumes a 32-bit avalon-mm slave with byte addresses inside one channel.
*/
// Functional notes
// - bit 6 follows pending loopback code request
// - reading loopback code status clears bit 6
// - bit 5 follows recovered clock loss declaration
// - bit 5 active only when detection enabled
// - bit 4 follows one second declaration
// - bit 3 follows any pending data link request
// - reading requesting data link status clears it
// - bit 2 follows pending slip buffer request
// - reading slip buffer status clears bit 2
// - bit 1 follows pending alarm/error request
// - reading requesting alarm status clears it
// - bit 0 follows pending framer request
// - reading framer status clears bit 0
`ifndef BIS_CONSTS_SVH
`define BIS_CONSTS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define BIS_OFF_SUMMARY 12'hb00
`define BIS_OFF_CFG 12'hb30
`define BIS_OFF_ISTAT 12'hb34
`define BIS_OFF_IMASK 12'hb38

// ****************************************************************
// summary bit positions
// ****************************************************************
`define BIS_BIT_RSVD 7
`define BIS_BIT_LOOP 6
`define BIS_BIT_CLKLOSS 5
`define BIS_BIT_SEC 4
`define BIS_BIT_HDLC 3
`define BIS_BIT_SLIP 2
`define BIS_BIT_ALARM 1
`define BIS_BIT_FRAMER 0

// ****************************************************************
// source vector layout (matches bis_pkg::bis_src_t)
// ****************************************************************
`define BIS_SRC_N 12
`define BIS_SRC_HDLC 11:6
`define BIS_SRC_ALARM 5:3
`define BIS_SRC_SLIP 2
`define BIS_SRC_FRAMER 1
`define BIS_SRC_LOOP 0

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define BIS_CFG_CLKLOSS_EN 0
`define BIS_SUM_W 8
`define BIS_IRQ_W 7
`define BIS_SUM_RST 8'h00
`define BIS_IRQ_RST 7'h00
`define BIS_CFG_RST 1'b0
`define BIS_DATA_RST 32'h0000_0000

`endif

// ===== src/bis_pkg.sv
/*
  types of the block interrupt summary.
  assumes the layout macros of bis_consts.svh.
*/
package bis_pkg;

  // ****************************************************************
  // one flag per source-level status register
  // ****************************************************************
  typedef struct packed {
    logic [5:0] hdlc;
    logic [2:0] alarm;
    logic slip;
    logic framer;
    logic loop;
  } bis_src_t;

  // ****************************************************************
  // declared framer levels
  // ****************************************************************
  typedef struct packed {
    logic clk_loss;
    logic one_sec;
  } bis_lvl_t;

  // ****************************************************************
  // bus answer state
  // ****************************************************************
  typedef enum logic [1:0] {
    BIS_IDLE = 2'b01,
    BIS_ACK = 2'b10
  } bis_bus_t;

endpackage

// ===== src/bis_block_irq_summary.sv
/*
  block interrupt summary: pending flags per source status register,
  summary register, interrupt status/mask and avalon-mm slave.
  assumes source events and source status read strobes are one-cycle
  pulses synchronous to mclk.
*/
`timescale 1ns/10ps
`include "bis_consts.svh"

module bis_block_irq_summary #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 32
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [DATA_W/8-1:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire bis_pkg::bis_src_t src_event,
  input wire bis_pkg::bis_src_t src_status_read,
  input wire bis_pkg::bis_lvl_t framer_level,
  output logic [`BIS_SUM_W-1:0] block_irq_summary,
  output logic irq
);

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (ADDR_W < 12 || DATA_W != 32) begin : g_bad_param
    $error("bis: ADDR_W must be >= 12 and DATA_W must be 32");
  end

  logic [`BIS_SRC_N-1:0] evt_v;
  logic [`BIS_SRC_N-1:0] rd_v;
  logic [`BIS_SRC_N-1:0] pend_q;
  logic [`BIS_SUM_W-1:0] summary_d;
  logic [`BIS_SUM_W-1:0] summary_q;
  logic [`BIS_IRQ_W-1:0] istat_q;
  logic [`BIS_IRQ_W-1:0] imask_q;
  logic [`BIS_IRQ_W-1:0] rise;
  logic cfg_clkloss_en_q;
  logic irq_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  bis_pkg::bis_bus_t bus_q;
  logic acc;
  logic wr_ok;
  logic [ADDR_W-1:0] off;

  assign evt_v = src_event;
  assign rd_v = src_status_read;

  // ****************************************************************
  // pending flags, one per source status register
  // ****************************************************************
  for (genvar i = 0; i < `BIS_SRC_N; i++) begin : g_pend
    always_ff @(posedge mclk) begin
      if (!resetn) begin
        pend_q[i] <= 1'b0;
      end else if (evt_v[i]) begin
        pend_q[i] <= 1'b1;
      end else if (rd_v[i]) begin
        pend_q[i] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // summary register
  // ****************************************************************
  always_comb begin
    summary_d = `BIS_SUM_RST;
    summary_d[`BIS_BIT_RSVD] = 1'b0;
    summary_d[`BIS_BIT_LOOP] = pend_q[`BIS_SRC_LOOP];
    summary_d[`BIS_BIT_CLKLOSS] = framer_level.clk_loss & cfg_clkloss_en_q;
    summary_d[`BIS_BIT_SEC] = framer_level.one_sec;
    summary_d[`BIS_BIT_HDLC] = |pend_q[`BIS_SRC_HDLC];
    summary_d[`BIS_BIT_SLIP] = pend_q[`BIS_SRC_SLIP];
    summary_d[`BIS_BIT_ALARM] = |pend_q[`BIS_SRC_ALARM];
    summary_d[`BIS_BIT_FRAMER] = pend_q[`BIS_SRC_FRAMER];
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      summary_q <= `BIS_SUM_RST;
    end else begin
      summary_q <= summary_d;
    end
  end

  assign block_irq_summary = summary_q;

  // ****************************************************************
  // bus handshake: one wait cycle, then answer
  // ****************************************************************
  assign acc = (avs_read | avs_write) & (bus_q == bis_pkg::BIS_ACK);
  assign wr_ok = acc & avs_write & avs_byteenable[0];
  assign off = avs_address;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      bus_q <= bis_pkg::BIS_IDLE;
    end else begin
      case (bus_q)
        bis_pkg::BIS_IDLE: begin
          if (avs_read | avs_write) begin
            bus_q <= bis_pkg::BIS_ACK;
          end
        end
        bis_pkg::BIS_ACK: begin
          bus_q <= bis_pkg::BIS_IDLE;
        end
        default: begin
          bus_q <= bis_pkg::BIS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & (bus_q == bis_pkg::BIS_IDLE));
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb begin
    rdata_d = `BIS_DATA_RST;
    if (off == ADDR_W'(`BIS_OFF_SUMMARY)) begin
      rdata_d[`BIS_SUM_W-1:0] = summary_q;
    end else if (off == ADDR_W'(`BIS_OFF_CFG)) begin
      rdata_d[`BIS_CFG_CLKLOSS_EN] = cfg_clkloss_en_q;
    end else if (off == ADDR_W'(`BIS_OFF_ISTAT)) begin
      rdata_d[`BIS_IRQ_W-1:0] = istat_q;
    end else if (off == ADDR_W'(`BIS_OFF_IMASK)) begin
      rdata_d[`BIS_IRQ_W-1:0] = imask_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata_q <= `BIS_DATA_RST;
    end else if (avs_read & (bus_q == bis_pkg::BIS_IDLE)) begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;

  // ****************************************************************
  // configuration register
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfg_clkloss_en_q <= `BIS_CFG_RST;
    end else if (wr_ok && off == ADDR_W'(`BIS_OFF_CFG)) begin
      cfg_clkloss_en_q <= avs_writedata[`BIS_CFG_CLKLOSS_EN];
    end
  end

  // ****************************************************************
  // interrupt status (w1c, set wins), mask, output
  // ****************************************************************
  assign rise = summary_d[`BIS_IRQ_W-1:0] & ~summary_q[`BIS_IRQ_W-1:0];

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      istat_q <= `BIS_IRQ_RST;
    end else if (wr_ok && off == ADDR_W'(`BIS_OFF_ISTAT)) begin
      istat_q <= (istat_q & ~avs_writedata[`BIS_IRQ_W-1:0]) | rise;
    end else begin
      istat_q <= istat_q | rise;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      imask_q <= `BIS_IRQ_RST;
    end else if (wr_ok && off == ADDR_W'(`BIS_OFF_IMASK)) begin
      imask_q <= avs_writedata[`BIS_IRQ_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(istat_q & imask_q);
    end
  end

  assign irq = irq_q;

endmodule // bis_block_irq_summary

// ===== tb/bis_sva.sv
/*
  checker of the summary outputs of the block interrupt summary.
  assumes binding to bis_block_irq_summary, ports by name.
*/
`timescale 1ns/10ps
module bis_sva (
  input wire logic mclk,
  input wire logic resetn,
  input wire bis_pkg::bis_src_t src_event,
  input wire bis_pkg::bis_src_t src_status_read,
  input wire bis_pkg::bis_lvl_t framer_level,
  input wire logic [7:0] block_irq_summary
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ****************************************************************
  // summary bits against their causes
  // ****************************************************************
  rsvd_zero_a: assert property (!block_irq_summary[7])
    else $error("reserved bit set");
  loop_set_a: assert property (src_event.loop |-> ##2 block_irq_summary[6])
    else $error("loop bit not set");
  loop_clr_a: assert property (src_status_read.loop && !src_event.loop |-> ##2
    !block_irq_summary[6]) else $error("loop bit not cleared");
  loss_low_a: assert property (!framer_level.clk_loss [*3] |=> !block_irq_summary[5])
    else $error("clock loss bit without cause");
  sec_high_a: assert property (framer_level.one_sec [*3] |=> block_irq_summary[4])
    else $error("second bit missing");
  link_set_a: assert property ((|src_event.hdlc) |-> ##2 block_irq_summary[3])
    else $error("link bit not set");
  slip_set_a: assert property (src_event.slip |-> ##2 block_irq_summary[2])
    else $error("slip bit not set");
  slip_clr_a: assert property (src_status_read.slip && !src_event.slip |-> ##2
    !block_irq_summary[2]) else $error("slip bit not cleared");
  alarm_set_a: assert property ((|src_event.alarm) |-> ##2 block_irq_summary[1])
    else $error("alarm bit not set");
  framer_set_a: assert property (src_event.framer |-> ##2 block_irq_summary[0])
    else $error("framer bit not set");
  framer_clr_a: assert property (src_status_read.framer && !src_event.framer |-> ##2
    !block_irq_summary[0]) else $error("framer bit not cleared");
endmodule // bis_sva

bind bis_block_irq_summary bis_sva u_sva (.mclk(mclk), .resetn(resetn),
  .src_event(src_event), .src_status_read(src_status_read),
  .framer_level(framer_level), .block_irq_summary(block_irq_summary));

// ===== tb/bis_block_irq_summary_tb_top.sv
/*
  self-checking bench of the block interrupt summary, random source traffic.
  assumes the design answers each bus request after one wait cycle.
*/
`timescale 1ns/10ps
module bis_block_irq_summary_tb_top;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] addr = 12'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] be = 4'hf;
  logic [31:0] rdata;
  logic wait_r;
  bis_pkg::bis_src_t ev = '0;
  bis_pkg::bis_src_t sr = '0;
  bis_pkg::bis_lvl_t lvl = '0;
  logic [7:0] sum;
  logic irq;
  logic [31:0] seed = 32'h0000_aa22;
  logic [31:0] q;
  logic [11:0] p = 12'h000;
  logic cl_en = 1'b0;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  always #5 mclk = ~mclk;
  bis_block_irq_summary dut (.mclk(mclk), .resetn(resetn), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(wait_r), .src_event(ev),
    .src_status_read(sr), .framer_level(lvl), .block_irq_summary(sum), .irq(irq));
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] exp_sum();
    return {24'h0, 1'b0, p[0], cl_en & lvl.clk_loss, lvl.one_sec, |p[11:6], p[2],
      |p[5:3], p[1]};
  endfunction
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    while (wait_r !== 1'b0) begin
      @(posedge mclk);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task pulse(input logic [11:0] e, input logic [11:0] r, input logic [1:0] l);
    @(posedge mclk);
    ev <= e;
    sr <= r;
    lvl <= l;
    @(posedge mclk);
    ev <= '0;
    sr <= '0;
    p = (p & ~r) | e;
    repeat (2) @(posedge mclk);
  endtask
  task test_done();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("reset sum", 32'h0000_0000, {24'h0, sum});
    bus(1'b1, 12'hb38, 32'h0000_0004);
    pulse(12'h004, 12'h000, 2'b00);
    repeat (2) @(posedge mclk);
    chk("irq on", 32'h0000_0001, {31'h0, irq});
    bus(1'b0, 12'hb34, 32'h0000_0000);
    chk("istat", 32'h0000_0004, q);
    pulse(12'h000, 12'h004, 2'b00);
    bus(1'b1, 12'hb34, 32'h0000_0004);
    bus(1'b0, 12'hb34, 32'h0000_0000);
    chk("istat clr", 32'h0000_0000, q);
    chk("irq off", 32'h0000_0000, {31'h0, irq});
    bus(1'b1, 12'hb00, 32'hffff_ffff);
    bus(1'b0, 12'hffc, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, q);
    bus(1'b0, 12'hb00, 32'h0000_0000);
    chk("sum after write", exp_sum(), q);
    be <= 4'he;
    bus(1'b1, 12'hb30, 32'h0000_0001);
    be <= 4'hf;
    bus(1'b0, 12'hb30, 32'h0000_0000);
    chk("cfg no lane", 32'h0000_0000, q);
    for (int i = 0; i < 40; i++) begin
      if (i == 20) begin
        bus(1'b1, 12'hb30, 32'h0000_0001);
        cl_en = 1'b1;
        bus(1'b0, 12'hb30, 32'h0000_0000);
        chk("cfg", 32'h0000_0001, q);
      end
      pulse(i == 0 ? 12'h0c3 : 12'(rnd()), i == 0 ? 12'h043 : 12'(rnd()), 2'(rnd()));
      chk("sum port", exp_sum(), {24'h0, sum});
      bus(1'b0, 12'hb00, 32'h0000_0000);
      chk("sum read", exp_sum(), q);
    end
    test_done();
  end
endmodule // bis_block_irq_summary_tb_top
